// ===== verilog/sram_link_pkg.sv
// Shared constants for the DDR burst-of-two SRAM port and its controller
package sram_link_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;          // Pins per beat
  localparam int LANE_W = 9;           // Bits per mask lane
  localparam int LANES = DATA_W / LANE_W;
  localparam int ADDR_W = 8;           // Base address width
  localparam int CODE_W = 6;           // Impedance code width
  // ----------------------------------------------------------------
  // Pipeline taps, in mclk ticks (half link cycles) after the
  // command edge; tap k is read at edge k+1 after that edge
  // ----------------------------------------------------------------
  localparam int PIPE_D = 6;
  localparam int TAP_WB1 = 1;          // First write beat edge
  localparam int TAP_WB2 = 2;          // Second write beat edge
  localparam int TAP_RB1 = 3;          // First read beat driven
  localparam int TAP_RB2 = 4;          // Second read beat driven
  localparam int TAP_TLO = 2;          // Termination off window start
  localparam int TAP_THI = 5;          // Termination off window end
  localparam int TAP_CAP1 = 4;         // Controller takes read beat 1
  localparam int TAP_CAP2 = 5;         // Controller takes read beat 2
  // ----------------------------------------------------------------
  // Calibration and buffering
  // ----------------------------------------------------------------
  localparam int CAL_CYCLES_DEF = 1024;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h20;
  localparam int RSP_DEPTH = 2;
endpackage

// ===== verilog/sram_link_if.sv
// Pin-level link between the SRAM port and its controller
`timescale 1ns/100ps
interface sram_link_if;
  // Command and clock phase, driven by the controller
  logic k_true;
  logic cmd_valid_n;
  logic rw;
  logic [sram_link_pkg::ADDR_W-1:0] addr;
  logic [sram_link_pkg::LANES-1:0] byte_mask_n;
  logic term_enable;
  // Data pins, one driver set for each end
  logic [sram_link_pkg::DATA_W-1:0] dq_c;
  logic dq_c_oe;
  logic [sram_link_pkg::DATA_W-1:0] dq_d;
  logic dq_d_oe;
  logic dq_term_on;
  logic [sram_link_pkg::DATA_W-1:0] dq;
  // Resolved pin level; an undriven pin shows the inverse of the
  // last controller value, so a sample in a dead tick is caught
  assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : ~dq_c);

  modport dev (
    input k_true, cmd_valid_n, rw, addr, byte_mask_n, term_enable, dq,
    output dq_d, dq_d_oe, dq_term_on
  );
  modport ctl (
    output k_true, cmd_valid_n, rw, addr, byte_mask_n, term_enable,
    output dq_c, dq_c_oe,
    input dq, dq_term_on
  );
endinterface

// ===== verilog/ddr_sram_device.sv
// Device end: common-I/O DDR SRAM port with burst-of-two transfers
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Overview of operation
// - Each command moves exactly two data beats
// - Controller may command every cycle or idle
// - Deselects pipeline like reads; read finishes first
// - Deselect ignores other inputs, drains pending bursts
// - Sample commands on true edge; read when selected
// - Write beats at next true, then complement
// - Read beat one at n+2, two follows
// - Masks sampled with their data beat
// - Masked lane keeps old stored contents
// - Masks independent per lane and per beat
// - Each write address takes two beats
// - Narrow variant masks four-bit nibbles alike
// - Free-running counter triggers periodic calibration
// - One code step per evaluation, termination too
// - Termination follows the enable input
// - Controller never floats masks or clocks
// - Data termination off around read driving
// - Controller drives except while reads return
// - Idle or write: drivers off 2 later
// - Drive-off level set by termination state; an undriven pin here shows the inverse of the last controller value
// - All lanes masked means nothing stored
// - Mask lane i governs its own bits
// ----------------------------------------------------------------
module ddr_sram_device #(
  parameter int CAL_CYCLES = sram_link_pkg::CAL_CYCLES_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link to the controller
  sram_link_if.dev link,
  // Calibration targets from the impedance resistor sense
  input wire logic [sram_link_pkg::CODE_W-1:0] drive_target,
  input wire logic [sram_link_pkg::CODE_W-1:0] term_target,
  // Calibration state
  output logic [sram_link_pkg::CODE_W-1:0] drive_code,
  output logic [sram_link_pkg::CODE_W-1:0] term_code,
  output logic cal_tick,
  // Termination on mask and clock receivers
  output logic ctl_term_on
);
  localparam int DW = sram_link_pkg::DATA_W;
  localparam int LW = sram_link_pkg::LANE_W;
  localparam int NL = 2 * sram_link_pkg::LANES;
  localparam int AW = sram_link_pkg::ADDR_W;
  localparam int CW = sram_link_pkg::CODE_W;
  localparam int PD = sram_link_pkg::PIPE_D;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Move a code one step toward its target
  function automatic logic [CW-1:0] step_toward(
    input logic [CW-1:0] cur,
    input logic [CW-1:0] tgt
  );
    logic [CW-1:0] res;
    res = cur;
    if (cur < tgt) begin
      res = cur + 1'b1;
    end else if (cur > tgt) begin
      res = cur - 1'b1;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic rd_cmd;
  logic wr_cmd;
  // Only the true edge loads; a high strobe loads nothing
  assign rd_cmd = link.k_true & ~link.cmd_valid_n & link.rw;
  assign wr_cmd = link.k_true & ~link.cmd_valid_n & ~link.rw;

  logic [PD-1:0] rd_pipe_ff;
  logic [PD-1:0] wr_pipe_ff;
  // Reads and writes ride twin tick pipelines; deselects shift zeros into both
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pipe_ff <= '0;
      wr_pipe_ff <= '0;
    end else begin
      rd_pipe_ff <= {rd_pipe_ff[PD-2:0], rd_cmd};
      wr_pipe_ff <= {wr_pipe_ff[PD-2:0], wr_cmd};
    end
  end

  // ----------------------------------------------------------------
  // Storage array, one double-width word per base address
  // ----------------------------------------------------------------
  logic [2*DW-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] waddr_ff;
  logic [AW-1:0] waddr2_ff;
  logic [DW-1:0] wbeat1_ff;
  logic [NL/2-1:0] wmask1_ff;
  logic [2*DW-1:0] wword;
  logic [NL-1:0] wmask;

  // Address held until the second beat lands
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      waddr_ff <= '0;
      waddr2_ff <= '0;
    end else begin
      if (wr_cmd) begin
        waddr_ff <= link.addr;
      end
      if (wr_pipe_ff[sram_link_pkg::TAP_WB1]) begin
        waddr2_ff <= waddr_ff;
      end
    end
  end

  // First beat and its mask caught at the next true edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wbeat1_ff <= '0;
      wmask1_ff <= '1;
    end else if (wr_pipe_ff[sram_link_pkg::TAP_WB1]) begin
      wbeat1_ff <= link.dq;
      wmask1_ff <= link.byte_mask_n;
    end
  end

  // Beat one fills the low half, beat two the high half
  assign wword = {link.dq, wbeat1_ff};
  assign wmask = {link.byte_mask_n, wmask1_ff};

  // Single masked commit on the complement edge
  always_ff @(posedge mclk) begin
    if (wr_pipe_ff[sram_link_pkg::TAP_WB2]) begin
      for (int i = 0; i < NL; i++) begin
        // Lane i owns bits i*LW up; nibbles on narrow builds
        if (!wmask[i]) begin
          mem[waddr2_ff][i*LW +: LW] <= wword[i*LW +: LW];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [2*DW-1:0] rd_a_ff;
  logic [2*DW-1:0] rd_b_ff;
  logic [DW-1:0] rd_hi_ff;
  logic [DW-1:0] dq_o_ff;
  logic dq_oe_ff;
  logic dq_term_ff;

  // Array read at the command edge, staged one cycle behind
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_a_ff <= '0;
      rd_b_ff <= '0;
    end else if (link.k_true) begin
      if (rd_cmd) begin
        rd_a_ff <= mem[link.addr];
      end
      rd_b_ff <= rd_a_ff;
    end
  end

  // Beat one at n+2, beat two at the following complement edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_o_ff <= '0;
      rd_hi_ff <= '0;
    end else if (rd_pipe_ff[sram_link_pkg::TAP_RB1]) begin
      dq_o_ff <= rd_b_ff[DW-1:0];
      rd_hi_ff <= rd_b_ff[2*DW-1:DW];
    end else if (rd_pipe_ff[sram_link_pkg::TAP_RB2]) begin
      dq_o_ff <= rd_hi_ff;
    end
  end

  // Drivers on only for read beats; idle or write turns them off
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_oe_ff <= 1'b0;
    end else begin
      dq_oe_ff <= rd_pipe_ff[sram_link_pkg::TAP_RB1] |
        rd_pipe_ff[sram_link_pkg::TAP_RB2];
    end
  end

  // Data termination drops half a cycle around read driving
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_term_ff <= 1'b0;
    end else begin
      dq_term_ff <= link.term_enable &
        ~(|rd_pipe_ff[sram_link_pkg::TAP_THI:sram_link_pkg::TAP_TLO]);
    end
  end

  // Mask and clock receivers follow the enable pin directly
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_term_on <= 1'b0;
    end else begin
      ctl_term_on <= link.term_enable;
    end
  end

  assign link.dq_d = dq_o_ff;
  assign link.dq_d_oe = dq_oe_ff;
  assign link.dq_term_on = dq_term_ff;

  // ----------------------------------------------------------------
  // Impedance calibration
  // ----------------------------------------------------------------
  logic [31:0] cal_cnt_ff;
  logic cal_due;
  assign cal_due = (cal_cnt_ff == 32'(CAL_CYCLES - 1));

  // Free-running cycle counter, restarts on each evaluation
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_cnt_ff <= '0;
      cal_tick <= 1'b0;
    end else begin
      cal_cnt_ff <= cal_due ? '0 : cal_cnt_ff + 32'h1;
      cal_tick <= cal_due;
    end
  end

  // One binary step per evaluation, driver and termination alike
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_code <= sram_link_pkg::CODE_RST;
      term_code <= sram_link_pkg::CODE_RST;
    end else if (cal_due) begin
      drive_code <= step_toward(drive_code, drive_target);
      term_code <= step_toward(term_code, term_target);
    end
  end
endmodule // ddr_sram_device

// ===== verilog/ddr_sram_ctrl.sv
// Controller end: drives commands and data to the DDR SRAM port
`timescale 1ns/100ps
module ddr_sram_ctrl #(
  parameter int DEPTH = sram_link_pkg::RSP_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link to the device
  sram_link_if.ctl link,
  // Request port
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_rw,
  input wire logic [sram_link_pkg::ADDR_W-1:0] req_addr,
  input wire logic [2*sram_link_pkg::DATA_W-1:0] req_wdata,
  input wire logic [2*sram_link_pkg::LANES-1:0] req_mask_n,
  // Read response port
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [2*sram_link_pkg::DATA_W-1:0] rsp_data,
  // Termination enable request
  input wire logic term_req
);
  localparam int DW = sram_link_pkg::DATA_W;
  localparam int NL = sram_link_pkg::LANES;
  localparam int PD = sram_link_pkg::PIPE_D;

  // ----------------------------------------------------------------
  // Phase and command
  // ----------------------------------------------------------------
  logic k_true_ff;
  logic cmd_n_ff;
  logic rw_ff;
  logic [sram_link_pkg::ADDR_W-1:0] addr_ff;
  logic [2*DW-1:0] hold_d_ff;
  logic [2*NL-1:0] hold_m_ff;
  logic wr_load_ff;
  logic take;
  logic [PD-1:0] rpipe_ff;
  logic [1:0] cnt_ff;
  logic [1:0] infl_ff;
  logic push;
  logic pop;

  assign take = ~k_true_ff & req_valid & req_ready;

  // Commands presented for the true-edge cycle only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      k_true_ff <= 1'b0;
      cmd_n_ff <= 1'b1;
      rw_ff <= 1'b1;
      addr_ff <= '0;
      hold_d_ff <= '0;
      hold_m_ff <= '1;
      wr_load_ff <= 1'b0;
    end else begin
      k_true_ff <= ~k_true_ff;
      cmd_n_ff <= ~take;
      wr_load_ff <= take & ~req_rw;
      if (take) begin
        rw_ff <= req_rw;
        addr_ff <= req_addr;
        hold_d_ff <= req_wdata;
        hold_m_ff <= req_mask_n;
      end
    end
  end

  // Mirror of the device read pipeline
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rpipe_ff <= '0;
    end else begin
      rpipe_ff <= {rpipe_ff[PD-2:0], k_true_ff & ~cmd_n_ff & rw_ff};
    end
  end

  // Ready: reads need buffer room, writes need bus turnaround;
  // judged only on a standing request, so req_rw is never stale
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= k_true_ff & req_valid & (req_rw ?
        (32'(cnt_ff) + 32'(infl_ff) < DEPTH) :
        ~(|rpipe_ff[3:0] | (~cmd_n_ff & rw_ff)));
    end
  end

  // ----------------------------------------------------------------
  // Write beats and pin drive
  // ----------------------------------------------------------------
  logic wr_smp_ff;
  logic b2_ff;
  logic [DW-1:0] beat2_ff;
  logic [NL-1:0] mask2_ff;
  logic [DW-1:0] dq_ff;
  logic [NL-1:0] mask_ff;
  logic oe_ff;

  // Beat one at next true edge, beat two at complement edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_smp_ff <= 1'b0;
      b2_ff <= 1'b0;
      beat2_ff <= '0;
      mask2_ff <= '1;
      dq_ff <= '0;
      mask_ff <= '1;
    end else begin
      wr_smp_ff <= wr_load_ff;
      b2_ff <= wr_smp_ff;
      if (wr_smp_ff) begin
        dq_ff <= hold_d_ff[DW-1:0];
        mask_ff <= hold_m_ff[NL-1:0];
        beat2_ff <= hold_d_ff[2*DW-1:DW];
        mask2_ff <= hold_m_ff[2*NL-1:NL];
      end else if (b2_ff) begin
        dq_ff <= beat2_ff;
        mask_ff <= mask2_ff;
      end else begin
        mask_ff <= '1; // Masks always at a valid level
      end
    end
  end

  // Release the pins from one tick before to one tick after the device drives them
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_ff <= 1'b1;
      link.term_enable <= 1'b0;
    end else begin
      oe_ff <= ~(|rpipe_ff[sram_link_pkg::TAP_THI:
        sram_link_pkg::TAP_TLO]);
      link.term_enable <= term_req;
    end
  end

  assign link.k_true = k_true_ff;
  assign link.cmd_valid_n = cmd_n_ff;
  assign link.rw = rw_ff;
  assign link.addr = addr_ff;
  assign link.byte_mask_n = mask_ff;
  assign link.dq_c = dq_ff;
  assign link.dq_c_oe = oe_ff;

  // ----------------------------------------------------------------
  // Read capture and two-entry response buffer
  // ----------------------------------------------------------------
  logic [DW-1:0] cap1_ff;
  logic [2*DW-1:0] rbuf [0:DEPTH-1];
  logic [0:0] wp_ff;
  logic [0:0] rp_ff;

  assign push = rpipe_ff[sram_link_pkg::TAP_CAP2];
  assign pop = rsp_valid & rsp_ready;

  // Beat one held until beat two arrives
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cap1_ff <= '0;
    end else if (rpipe_ff[sram_link_pkg::TAP_CAP1]) begin
      cap1_ff <= link.dq;
    end
  end

  // Buffer storage
  always_ff @(posedge mclk) begin
    if (push) begin
      rbuf[wp_ff] <= {link.dq, cap1_ff};
    end
  end

  // Pointers, fill count and outstanding reads
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      infl_ff <= '0;
      rsp_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
      infl_ff <= infl_ff + 2'(take & req_rw) - 2'(push);
      rsp_valid <= (cnt_ff + 2'(push) - 2'(pop)) != 2'h0;
    end
  end

  assign rsp_data = rbuf[rp_ff];
endmodule // ddr_sram_ctrl

// ===== verif/sram_link_asserts.sv
// Concurrent checks on the SRAM link pins
`timescale 1ns/100ps
module sram_link_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command pins
  input wire logic k_true,
  input wire logic cmd_valid_n,
  input wire logic rw,
  input wire logic [sram_link_pkg::LANES-1:0] byte_mask_n,
  input wire logic term_enable,
  // Data pin control
  input wire logic dq_c_oe,
  input wire logic dq_d_oe,
  input wire logic dq_term_on
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Command decode and transfer steps
  // ----------------------------------------------------------------
  wire rd_cmd = k_true & ~cmd_valid_n & rw;
  wire wr_cmd = k_true & ~cmd_valid_n & ~rw;
  sequence s_rd_beats;
    dq_d_oe [*2];
  endsequence
  sequence s_term_gap;
    !dq_term_on [*4];
  endsequence
  sequence s_wr_beats;
    (dq_c_oe && !dq_d_oe) [*2];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CMD_ON_TRUE:
    assert property (!cmd_valid_n |-> k_true) else $error("cmd phase");
  AST_RD_BEATS:
    assert property (rd_cmd |-> ##5 s_rd_beats) else $error("rd beats");
  AST_DRV_OFF:
    assert property (k_true && !rd_cmd |-> ##5 !dq_d_oe [*2])
      else $error("drive off");
  AST_TERM_GAP:
    assert property (rd_cmd && term_enable |-> ##4 s_term_gap)
      else $error("term gap");
  AST_TERM_LEAD:
    assert property ($rose(dq_d_oe) |-> !$past(dq_term_on))
      else $error("term lead");
  AST_TERM_BACK:
    assert property ($fell(dq_d_oe) && term_enable && !$past(rd_cmd, 3)
      |=> dq_term_on) else $error("term back");
  AST_NO_FIGHT:
    assert property (!(dq_d_oe && dq_c_oe)) else $error("dq fight");
  AST_CTL_RELEASE:
    assert property (rd_cmd |-> ##4 !dq_c_oe [*4]) else $error("release");
  AST_WR_BEATS:
    assert property (wr_cmd |-> ##2 s_wr_beats) else $error("wr beats");
  AST_MASK_IDLE:
    assert property (k_true && !wr_cmd |-> ##2 (&byte_mask_n) [*2])
      else $error("mask idle");
  AST_TERM_OFF:
    assert property (!term_enable [*3] |-> !dq_term_on)
      else $error("term off");
endmodule // sram_link_asserts

// ===== verif/tb_top.sv
// Self-checking bench for the SRAM port and controller pair
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // Sizes and bench state
  // ----------------------------------------------------------------
  localparam int WW = 2*sram_link_pkg::DATA_W;
  localparam int DW = sram_link_pkg::DATA_W;
  localparam int LW = sram_link_pkg::LANE_W;
  localparam int NL = 2*sram_link_pkg::LANES;
  localparam int AW = sram_link_pkg::ADDR_W;
  localparam int CW = sram_link_pkg::CODE_W;
  localparam int CAL_N = 8;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic req_valid = 1'h0;
  logic req_rw = 1'h0;
  logic [AW-1:0] req_addr = '0;
  logic [WW-1:0] req_wdata = '0;
  logic [NL-1:0] req_mask_n = '1;
  logic rsp_ready = 1'h1;
  logic term_req = 1'h0;
  logic [CW-1:0] drive_target = 6'h22;
  logic [CW-1:0] term_target = 6'h1e;
  logic req_ready;
  logic rsp_valid;
  logic [WW-1:0] rsp_data;
  logic [CW-1:0] drive_code;
  logic [CW-1:0] term_code;
  logic cal_tick;
  logic ctl_term_on;
  logic [CW-1:0] prev_c [4];
  logic [WW-1:0] shadow [int];
  logic [WW-1:0] exp_q [$];
  logic [DW-1:0] beat_q [$];
  logic [DW-1:0] b1;
  int err_total = 0;
  int n_tests = 0;
  int cal_gap = 0;
  int seen = 0;
  int hits;
  // Clock
  initial begin
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Design pair and checker
  // ----------------------------------------------------------------
  sram_link_if sram_link_if_i ();
  ddr_sram_device #(.CAL_CYCLES(CAL_N)) ddr_sram_device_i (
    .mclk(mclk), .sys_rst(sys_rst), .link(sram_link_if_i.dev),
    .drive_target(drive_target), .term_target(term_target),
    .drive_code(drive_code), .term_code(term_code),
    .cal_tick(cal_tick), .ctl_term_on(ctl_term_on));
  ddr_sram_ctrl ddr_sram_ctrl_i (
    .mclk(mclk), .sys_rst(sys_rst), .link(sram_link_if_i.ctl),
    .req_valid(req_valid), .req_ready(req_ready), .req_rw(req_rw),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_mask_n(req_mask_n),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .term_req(term_req));
  sram_link_asserts sram_link_asserts_i (
    .mclk(mclk), .sys_rst(sys_rst),
    .k_true(sram_link_if_i.k_true),
    .cmd_valid_n(sram_link_if_i.cmd_valid_n),
    .rw(sram_link_if_i.rw),
    .byte_mask_n(sram_link_if_i.byte_mask_n),
    .term_enable(sram_link_if_i.term_enable),
    .dq_c_oe(sram_link_if_i.dq_c_oe),
    .dq_d_oe(sram_link_if_i.dq_d_oe),
    .dq_term_on(sram_link_if_i.dq_term_on));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [WW-1:0] e,
                     input logic [WW-1:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic stop(input string what);
    err_total++;
    $display("[ERR] %s expected done seen timeout", what);
    wrap_up();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Offer one request, held until taken on a low k_true edge
  task automatic issue(input logic rw, input logic [AW-1:0] a,
                       input logic [WW-1:0] d, input logic [NL-1:0] m);
    int i;
    @(posedge mclk);
    req_valid <= 1'h1;
    req_rw <= rw;
    req_addr <= a;
    req_wdata <= d;
    req_mask_n <= m;
    for (i = 0; i < 64; i++) begin
      @(negedge mclk);
      if (req_ready === 1'h1 && sram_link_if_i.k_true === 1'h0) break;
    end
    if (i == 64) stop("request take");
    @(posedge mclk);
    req_valid <= 1'h0;
  endtask
  // Write with lane masks, mirrored in the shadow array
  task automatic wr(input logic [AW-1:0] a, input logic [WW-1:0] d,
                    input logic [NL-1:0] m);
    logic [WW-1:0] r;
    r = shadow.exists(a) ? shadow[a] : 'x;
    for (int j = 0; j < NL; j++) begin
      if (!m[j]) r[j*LW +: LW] = d[j*LW +: LW];
    end
    shadow[a] = r;
    issue(1'h0, a, d, m);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    exp_q.push_back(shadow[a]);
    issue(1'h1, a, '0, '1);
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge mclk);
      if (exp_q.size() == 0 && rsp_valid === 1'h0) break;
    end
    if (i == 200) stop("read drain");
  endtask
  function automatic logic [CW-1:0] step(input logic [CW-1:0] c,
                                         input logic [CW-1:0] t);
    if (t > c) return c + 6'h01;
    if (t < c) return c - 6'h01;
    return c;
  endfunction
  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Wire beats and response words against the shadow
  always @(negedge mclk) begin
    if (sys_rst === 1'h0 && sram_link_if_i.dq_d_oe === 1'h1) begin
      beat_q.push_back(sram_link_if_i.dq);
    end
    if (sys_rst === 1'h0 && rsp_valid === 1'h1 && rsp_ready === 1'h1) begin
      if (exp_q.size() < 1 || beat_q.size() < 2) stop("response");
      b1 = beat_q.pop_front();
      chk("read word", exp_q[0], rsp_data);
      chk("wire beats", exp_q.pop_front(), {beat_q.pop_front(), b1});
    end
  end
  // Calibration period and single steps toward target
  always @(negedge mclk) begin
    if (sys_rst === 1'h1) begin
      seen = 0;
    end else if (cal_tick === 1'h1) begin
      if (seen == 1) chk("cal period", CAL_N, cal_gap);
      chk("drive code", step(prev_c[0], prev_c[2]), drive_code);
      chk("term code", step(prev_c[1], prev_c[3]), term_code);
      seen = 1;
      cal_gap = 0;
    end else begin
      chk("code hold", {prev_c[0], prev_c[1]}, {drive_code, term_code});
    end
    cal_gap++;
    prev_c = '{drive_code, term_code, drive_target, term_target};
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    chk("reset codes", 12'h820, {drive_code, term_code});
    chk("reset flags", 5'h01, {cal_tick, req_ready, rsp_valid,
        sram_link_if_i.dq_d_oe, sram_link_if_i.cmd_valid_n});
    sys_rst <= 1'h0;
    wr(8'h05, 36'h9_8765_4321, 4'h0);
    wr(8'h06, 36'h0_aaaa_5555, 4'h0);
    idle(6);
    rd(8'h05);
    rd(8'h06);
    // Lane 0 in beat one, lane 1 in beat two, then a full abort
    wr(8'h05, 36'hf_0f0f_0f0f, 4'h6);
    wr(8'h06, 36'h3_3333_3333, 4'hf);
    idle(6);
    rd(8'h05);
    rd(8'h06);
    wr(8'h20, 36'h0, 4'h0);
    for (int k = 0; k < NL; k++) begin
      wr(8'h20, 36'h5_a5a5_a5a5 ^ k, ~(4'h1 << k));
      idle(6);
      rd(8'h20);
    end
    drain();
    // Termination on while idle and around traffic
    @(posedge mclk);
    term_req <= 1'h1;
    drive_target <= 6'h1c;
    idle(8);
    chk("term on", 2'h3, {sram_link_if_i.dq_term_on, ctl_term_on});
    wr(8'h07, 36'h1_2481_2481, 4'h0);
    idle(6);
    rd(8'h07);
    drain();
    idle(4);
    chk("term idle", 1'h1, sram_link_if_i.dq_term_on);
    @(posedge mclk);
    term_req <= 1'h0;
    idle(8);
    chk("term off", 2'h0, {sram_link_if_i.dq_term_on, ctl_term_on});
    // Receiver stalls: two reads fill the buffer, a third waits
    @(posedge mclk);
    rsp_ready <= 1'h0;
    rd(8'h05);
    rd(8'h06);
    fork
      rd(8'h07);
    join_none
    hits = 0;
    repeat (24) begin
      @(negedge mclk);
      if (req_ready === 1'h1) hits++;
    end
    chk("held off", 0, hits);
    chk("buffer full", 1'h1, rsp_valid);
    @(posedge mclk);
    rsp_ready <= 1'h1;
    drain();
    wait fork;
    // Second reset in mid-run
    @(posedge mclk);
    sys_rst <= 1'h1;
    idle(3);
    chk("rerun codes", 12'h820, {drive_code, term_code});
    @(posedge mclk);
    sys_rst <= 1'h0;
    // Traffic resumes; the array keeps its contents through reset
    wr(8'h09, 36'h6_1357_9bdf, 4'h0);
    idle(6);
    rd(8'h09);
    rd(8'h05);
    drain();
    idle(40);
    wrap_up();
  end
endmodule // tb_top
